// ### rtl/rtc_time_alarm_value_regs.sv
// Our own choices: the AXI4-Lite register port and the address map.
`timescale 1ns/10ps
module rtc_time_alarm_value_regs (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready
);
    typedef struct packed {
        logic wren;
        logic [1:0] time_ptr;
        logic [1:0] alarm_ptr;
        logic [15:0] time_weekday_hours;
        logic [15:0] time_minutes_seconds;
        logic [15:0] alarm_month_day;
        logic [15:0] alarm_weekday_hours;
        logic [15:0] alarm_minutes_seconds;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
    } state_s;

    state_s q;
    state_s d;
    logic wr_go;
    logic rd_go;

    // Saturating step of a window pointer
    function automatic logic [1:0] step_down(input logic [1:0] ptr);
        step_down = (ptr == 2'h0) ? 2'h0 : ptr - 2'h1;
    endfunction

    // Byte-lane merge limited to the implemented bits
    function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] din,
                                          input logic [1:0] lanes, input logic [15:0] mask);
        logic [15:0] lane_mask;
        lane_mask = {{8{lanes[1]}}, {8{lanes[0]}}};
        merge = ((old & ~lane_mask) | (din & lane_mask)) & mask;
    endfunction

    function automatic logic mapped(input logic [7:0] addr);
        mapped = (addr == rtc_value_pkg::CTRL_ADDR) || (addr == rtc_value_pkg::TIME_PTR_ADDR)
            || (addr == rtc_value_pkg::TIME_WIN_ADDR) || (addr == rtc_value_pkg::ALARM_PTR_ADDR)
            || (addr == rtc_value_pkg::ALARM_WIN_ADDR);
    endfunction

    // Address and data are taken together in one handshake
    assign awready = awvalid && wvalid && !q.bvalid;
    assign wready = awready;
    assign wr_go = awready;
    assign arready = !q.rvalid;
    assign rd_go = arvalid && arready;

    assign bvalid = q.bvalid;
    assign bresp = q.bresp;
    assign rvalid = q.rvalid;
    assign rresp = q.rresp;
    assign rdata = q.rdata;

    always_comb begin
        logic [1:0] lanes;
        logic upper_wr;
        lanes = wstrb[1:0];
        upper_wr = wstrb[rtc_value_pkg::HI_LANE];
        d = q;

        if (q.bvalid && bready) begin
            d.bvalid = 1'b0;
        end
        if (q.rvalid && rready) begin
            d.rvalid = 1'b0;
        end

        // Read path sees the state before any write of the same cycle
        if (rd_go) begin
            d.rvalid = 1'b1;
            d.rresp = rtc_value_pkg::RESP_OKAY;
            d.rdata = 32'h0;
            unique case (araddr)
                rtc_value_pkg::CTRL_ADDR: begin
                    d.rdata[rtc_value_pkg::WREN_BIT] = q.wren;
                end
                rtc_value_pkg::TIME_PTR_ADDR: begin
                    d.rdata[1:0] = q.time_ptr;
                end
                rtc_value_pkg::ALARM_PTR_ADDR: begin
                    d.rdata[1:0] = q.alarm_ptr;
                end
                rtc_value_pkg::TIME_WIN_ADDR: begin
                    if (q.time_ptr == rtc_value_pkg::PTR_WEEKDAY_HOURS) begin
                        d.rdata[15:0] = q.time_weekday_hours
                            & rtc_value_pkg::WEEKDAY_HOURS_MASK;
                    end else if (q.time_ptr == rtc_value_pkg::PTR_MINUTES_SECONDS) begin
                        d.rdata[15:0] = q.time_minutes_seconds
                            & rtc_value_pkg::MINUTES_SECONDS_MASK;
                    end
                end
                rtc_value_pkg::ALARM_WIN_ADDR: begin
                    unique case (q.alarm_ptr)
                        rtc_value_pkg::PTR_MONTH_DAY: begin
                            d.rdata[15:0] = q.alarm_month_day
                                & rtc_value_pkg::MONTH_DAY_MASK;
                        end
                        rtc_value_pkg::PTR_WEEKDAY_HOURS: begin
                            d.rdata[15:0] = q.alarm_weekday_hours
                                & rtc_value_pkg::WEEKDAY_HOURS_MASK;
                        end
                        rtc_value_pkg::PTR_MINUTES_SECONDS: begin
                            d.rdata[15:0] = q.alarm_minutes_seconds
                                & rtc_value_pkg::MINUTES_SECONDS_MASK;
                        end
                        default: begin
                            d.rdata[15:0] = 16'h0;
                        end
                    endcase
                end
                default: begin
                    d.rresp = rtc_value_pkg::RESP_SLVERR;
                end
            endcase
        end

        if (wr_go) begin
            d.bvalid = 1'b1;
            d.bresp = mapped(awaddr) ? rtc_value_pkg::RESP_OKAY : rtc_value_pkg::RESP_SLVERR;
            unique case (awaddr)
                rtc_value_pkg::CTRL_ADDR: begin
                    if (wstrb[0]) begin
                        d.wren = wdata[rtc_value_pkg::WREN_BIT];
                    end
                end
                rtc_value_pkg::TIME_PTR_ADDR: begin
                    if (wstrb[0]) begin
                        d.time_ptr = wdata[1:0];
                    end
                end
                rtc_value_pkg::ALARM_PTR_ADDR: begin
                    if (wstrb[0]) begin
                        d.alarm_ptr = wdata[1:0];
                    end
                end
                rtc_value_pkg::TIME_WIN_ADDR: begin
                    // Weekday hour tens hour ones
                    if (q.time_ptr == rtc_value_pkg::PTR_WEEKDAY_HOURS && q.wren) begin
                        d.time_weekday_hours = merge(q.time_weekday_hours, wdata[15:0],
                            lanes, rtc_value_pkg::WEEKDAY_HOURS_MASK);
                    end
                    // Minute digits second digits
                    if (q.time_ptr == rtc_value_pkg::PTR_MINUTES_SECONDS) begin
                        d.time_minutes_seconds = merge(q.time_minutes_seconds, wdata[15:0],
                            lanes, rtc_value_pkg::MINUTES_SECONDS_MASK);
                    end
                end
                rtc_value_pkg::ALARM_WIN_ADDR: begin
                    unique case (q.alarm_ptr)
                        rtc_value_pkg::PTR_MONTH_DAY: begin
                            // Month tens month ones day
                            if (q.wren) begin
                                d.alarm_month_day = merge(q.alarm_month_day, wdata[15:0],
                                    lanes, rtc_value_pkg::MONTH_DAY_MASK);
                            end
                        end
                        rtc_value_pkg::PTR_WEEKDAY_HOURS: begin
                            if (q.wren) begin
                                d.alarm_weekday_hours = merge(q.alarm_weekday_hours,
                                    wdata[15:0], lanes,
                                    rtc_value_pkg::WEEKDAY_HOURS_MASK);
                            end
                        end
                        rtc_value_pkg::PTR_MINUTES_SECONDS: begin
                            d.alarm_minutes_seconds = merge(q.alarm_minutes_seconds,
                                wdata[15:0], lanes,
                                rtc_value_pkg::MINUTES_SECONDS_MASK);
                        end
                        default: begin
                        end
                    endcase
                end
                default: begin
                end
            endcase
        end

        // Pointer steps after an upper-half access; a pointer write in the
        // same cycle wins over the step
        if (!(wr_go && awaddr == rtc_value_pkg::TIME_PTR_ADDR && wstrb[0])) begin
            if (rd_go && araddr == rtc_value_pkg::TIME_WIN_ADDR) begin
                d.time_ptr = step_down(d.time_ptr);
            end
            if (wr_go && awaddr == rtc_value_pkg::TIME_WIN_ADDR && upper_wr) begin
                d.time_ptr = step_down(d.time_ptr);
            end
        end
        if (!(wr_go && awaddr == rtc_value_pkg::ALARM_PTR_ADDR && wstrb[0])) begin
            if (rd_go && araddr == rtc_value_pkg::ALARM_WIN_ADDR) begin
                d.alarm_ptr = step_down(d.alarm_ptr);
            end
            if (wr_go && awaddr == rtc_value_pkg::ALARM_WIN_ADDR && upper_wr) begin
                d.alarm_ptr = step_down(d.alarm_ptr);
            end
        end
    end

    // Digit words keep their contents across reset
    always_ff @(posedge aclk) begin
        q <= d;
        if (!aresetn) begin
            q.wren <= rtc_value_pkg::WREN_RESET;
            q.time_ptr <= rtc_value_pkg::PTR_RESET;
            q.alarm_ptr <= rtc_value_pkg::PTR_RESET;
            q.bvalid <= 1'b0;
            q.bresp <= rtc_value_pkg::RESP_OKAY;
            q.rvalid <= 1'b0;
            q.rresp <= rtc_value_pkg::RESP_OKAY;
            q.rdata <= 32'h0;
        end
    end
endmodule

// ### rtl/rtc_value_pkg.sv
// Contract
// - Weekday digit in bits 10-8, 0 to 6
// - Hour tens digit in bits 5-4, 0-2
// - Hour ones digit in bits 3-0, 0-9
// - Minute tens digit in bits 14-12, 0-5
// - Minute ones digit in bits 11-8, 0-9
// - Second tens digit in bits 6-4, 0-5
// - Second ones digit in bits 3-0, 0-9
// - Alarm month tens bit at bit 12
// - Alarm month ones digit in bits 11-8
// - Alarm day tens digit in bits 5-4
// - Alarm day ones digit in bits 3-0
// - Gated words writable only with write enable set
// - Unimplemented bits read zero, writes dropped
// - Time pointer 01 weekday/hours, 00 minutes/seconds
// - Alarm pointer 10 month/day, 01 weekday/hours, 00 min/sec
// - Time pointer decrements on upper-half access, stops 00
// - Alarm pointer decrements on upper-half access, stops 00
package rtc_value_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int STRB_W = 4;

    // Register byte addresses
    localparam logic [7:0] CTRL_ADDR = 8'h00;
    localparam logic [7:0] TIME_PTR_ADDR = 8'h04;
    localparam logic [7:0] TIME_WIN_ADDR = 8'h08;
    localparam logic [7:0] ALARM_PTR_ADDR = 8'h0c;
    localparam logic [7:0] ALARM_WIN_ADDR = 8'h10;

    // Field positions
    localparam int WREN_BIT = 0;
    localparam int HI_LANE = 1;
    localparam int LO_LANE = 0;

    // Window pointer codes
    localparam logic [1:0] PTR_MONTH_DAY = 2'h2;
    localparam logic [1:0] PTR_WEEKDAY_HOURS = 2'h1;
    localparam logic [1:0] PTR_MINUTES_SECONDS = 2'h0;

    // Implemented bits of each value word
    localparam logic [15:0] WEEKDAY_HOURS_MASK = 16'h073f;
    localparam logic [15:0] MINUTES_SECONDS_MASK = 16'h7f7f;
    localparam logic [15:0] MONTH_DAY_MASK = 16'h1f3f;

    // Values after reset
    localparam logic WREN_RESET = 1'h0;
    localparam logic [1:0] PTR_RESET = 2'h0;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ### test/rtc_value_chk_sva.sv
`timescale 1ns/10ps
module rtc_value_chk (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic awvalid,
    input wire logic awready,
    input wire logic wvalid,
    input wire logic wready,
    input wire logic [1:0] bresp,
    input wire logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic [31:0] rdata,
    input wire logic [1:0] rresp,
    input wire logic rvalid,
    input wire logic rready
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    AST_WR_ANSWER: assert property (awvalid && wvalid && !bvalid |=> bvalid)
        else $error("write not answered");
    AST_WR_READY: assert property (awready == (awvalid && wvalid && !bvalid) && wready == awready)
        else $error("write ready wrong");
    AST_RD_ANSWER: assert property (arvalid && !rvalid |=> rvalid)
        else $error("read not answered");
    AST_RD_READY: assert property (arready == !rvalid)
        else $error("read ready wrong");
    AST_B_HOLD: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write response dropped");
    AST_R_HOLD: assert property (rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
        else $error("read response dropped");
    AST_R_DROP: assert property (rvalid && rready |=> !rvalid)
        else $error("read response not released");
    AST_RD_ZERO: assert property (rvalid |-> rdata[31:16] == 16'h0 && !rdata[15] && !rdata[7])
        else $error("unimplemented bit set");
    AST_UNMAPPED: assert property (arvalid && !rvalid && araddr > 8'h10 |=> rresp == 2'h2)
        else $error("unmapped read not refused");
endmodule
bind rtc_time_alarm_value_regs rtc_value_chk chk (.aclk, .aresetn, .awvalid, .awready, .wvalid,
    .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
    .rready);

// ### test/rtc_time_alarm_value_regs_tb.sv
`timescale 1ns/10ps
module rtc_time_alarm_value_regs_tb;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'h0;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic bready = 1'b1;
    logic arvalid = 1'b0;
    logic rready = 1'b1;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    int err_total = 0;
    int samples_checked = 0;
    int cycles = 0;
    logic [31:0] aw [3] = '{32'hffff_f131, 32'hffff_fe17, 32'hffff_c845};
    logic [31:0] ae [3] = '{32'h1131, 32'h0617, 32'h4845};
    always #20 aclk = ~aclk;
    rtc_time_alarm_value_regs dut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb,
        .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
        .rvalid, .rready);
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    always @(posedge aclk) begin
        cycles++;
        if (cycles == 5000) begin
            err_total++;
            end_of_test();
        end
    end
    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(logic [7:0] a, logic [31:0] d, logic [3:0] s = 4'h3, logic [1:0] r = 2'h0);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do @(posedge aclk); while (awready !== 1'b1 || wready !== 1'b1);
        awvalid <= 1'b0;
        wvalid <= 1'b0;
        do @(posedge aclk); while (bvalid !== 1'b1);
        check("bresp", {30'h0, bresp}, {30'h0, r});
    endtask
    task automatic rd(logic [7:0] a, logic [31:0] e, logic [1:0] r = 2'h0, int st = 0);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= (st == 0);
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge aclk); while (rvalid !== 1'b1);
        if (st > 0) begin
            repeat (st) @(posedge aclk);
            rready <= 1'b1;
            @(posedge aclk);
        end
        check("rdata", rdata, e);
        check("rresp", {30'h0, rresp}, {30'h0, r});
    endtask
    task automatic t_bus();
        rd(8'h00, 32'h0);
        rd(8'h04, 32'h0);
        rd(8'h0c, 32'h0);
        rd(8'h14, 32'h0, 2'h2);
        wr(8'h14, 32'h1, 4'hf, 2'h2);
        $display("bus test done");
    endtask
    task automatic t_time();
        wr(8'h00, 32'h1, 4'h1);
        wr(8'h04, 32'h1, 4'h1);
        wr(8'h08, 32'hffff_f9e3);
        rd(8'h04, 32'h0);
        wr(8'h08, 32'hffff_d959);
        rd(8'h04, 32'h0);
        rd(8'h08, 32'h5959, 2'h0, 3);
        wr(8'h00, 32'h0, 4'h1);
        wr(8'h04, 32'h1, 4'h1);
        wr(8'h08, 32'h0512);
        wr(8'h04, 32'h1, 4'h1);
        rd(8'h08, 32'h0123);
        wr(8'h08, 32'h1234);
        rd(8'h08, 32'h1234);
        wr(8'h04, 32'h3, 4'h1);
        rd(8'h08, 32'h0);
        rd(8'h04, 32'h2);
        $display("time test done");
    endtask
    task automatic t_alarm();
        wr(8'h00, 32'h1, 4'h1);
        wr(8'h0c, 32'h2, 4'h1);
        foreach (aw[i]) wr(8'h10, aw[i]);
        rd(8'h0c, 32'h0);
        wr(8'h0c, 32'h2, 4'h1);
        foreach (ae[i]) rd(8'h10, ae[i]);
        wr(8'h00, 32'h0, 4'h1);
        wr(8'h0c, 32'h2, 4'h1);
        wr(8'h10, 32'h0);
        wr(8'h0c, 32'h2, 4'h1);
        rd(8'h10, 32'h1131);
        wr(8'h00, 32'h1, 4'h1);
        wr(8'h0c, 32'h1, 4'h1);
        wr(8'h10, 32'h5, 4'h1);
        rd(8'h0c, 32'h1);
        rd(8'h10, 32'h0605);
        wr(8'h0c, 32'h3, 4'h1);
        rd(8'h10, 32'h0);
        rd(8'h0c, 32'h2);
        $display("alarm test done");
    endtask
    initial begin
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_bus();
        t_time();
        t_alarm();
        end_of_test();
    end
endmodule
